/* File: rtl/clk_mode_consts.svh */
`ifndef CLK_MODE_CONSTS_SVH
`define CLK_MODE_CONSTS_SVH
// register byte addresses
`define ADDR_SYS_CLK_SEL 4'h0
`define ADDR_FAST_RC_CTL 4'h4
`define ADDR_FAST_XT_CTL 4'h8
`define ADDR_SLOW_XT_CTL 4'hc
// system clock select fields
`define SCC_DIV_MSB 7
`define SCC_DIV_LSB 5
`define SCC_FAST_SRC 3
`define SCC_SLOW_SRC 2
`define SCC_FAST_KEEP 1
`define SCC_SLOW_KEEP 0
`define DIV_SEL_SLOW 3'h7
// oscillator control fields
`define RC_FREQ_MSB 3
`define RC_FREQ_LSB 2
`define OSC_MODE_BIT 2
`define OSC_STABLE_BIT 1
`define OSC_ENABLE_BIT 0
// reset values
`define SCC_RESET 8'h00
`define RC_CTL_RESET 8'h01
`define XT_CTL_RESET 8'h00
// stabilisation times in us and cycle counts at 10 MHz
`define CLK_MHZ 10
`define RC_SETTLE_US 16
`define XT_FAST_SETTLE_US 128
`define XT_SLOW_SETTLE_US 400
`define RC_SETTLE_CYC (`RC_SETTLE_US * `CLK_MHZ)
`define XT_FAST_SETTLE_CYC (`XT_FAST_SETTLE_US * `CLK_MHZ)
`define XT_SLOW_SETTLE_CYC (`XT_SLOW_SETTLE_US * `CLK_MHZ)
`define SETTLE_W 12
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: rtl/clk_mode_pkg.sv */
package clk_mode_pkg;
  // operating modes
  typedef enum logic [2:0]
  {
    MODE_FAST = 3'h0,
    MODE_SLOW = 3'h1,
    MODE_SLEEP = 3'h2,
    MODE_STANDBY_SLOW_ONLY = 3'h3,
    MODE_STANDBY_BOTH_CLOCKS = 3'h4,
    MODE_STANDBY_FAST_ONLY = 3'h5
  } op_mode_e;
  // rc frequency codes
  typedef enum logic [1:0]
  {
    RC_8MHZ = 2'h0,
    RC_12MHZ = 2'h1,
    RC_16MHZ = 2'h2,
    RC_8MHZ_ALT = 2'h3
  } rc_freq_e;
endpackage

/* File: rtl/osc_settle.sv */
`timescale 1ns/10ps
`include "clk_mode_consts.svh"
module osc_settle #(
  parameter logic [`SETTLE_W-1:0] SETTLE_CYC = 12'd1
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // restart pulse and enable
  input wire logic restart_i,
  osc_settle_if.osc port
);
  logic [`SETTLE_W-1:0] count;
  logic stable;
  // stable clears on restart or disable, sets when count expires
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i || restart_i || !port.enable)
    begin
      count <= '0;
      stable <= 1'b0;
    end
    else if (count + 12'd1 >= SETTLE_CYC)
      stable <= 1'b1;
    else
      count <= count + 12'd1;
  end
  assign port.stable = stable;
endmodule

/* File: rtl/osc_settle_if.sv */
`timescale 1ns/10ps
interface osc_settle_if;
  logic enable;
  logic stable;
  modport ctrl (output enable, input stable);
  modport osc (input enable, output stable);
endinterface

/* File: rtl/system_clock_mode_control.sv */
// Operation
// - divider code 0..6 gives fast clock /1../64, code 7 selects slow clock
// - fast source bit 0 picks internal rc, 1 picks external crystal
// - slow source bit 0 picks internal slow rc, 1 picks slow crystal
// - stop with both keep-alive low is sleep; slow rc runs only with watchdog
// - stop with only slow keep-alive keeps slow clock, stops fast
// - stop with both keep-alive high keeps both clocks running
// - stop with only fast keep-alive keeps fast clock, stops slow
// - in slow mode fast clock follows its own oscillator enable
// - rc code 00 8MHz, 01 12MHz, 10 16MHz, 11 8MHz
// - new rc frequency applies only once rc stable flag is set
// - setting rc enable clears rc stable, which sets after settling
// - setting fast crystal enable clears its stable flag, then sets it
// - setting slow crystal enable clears its stable flag, then sets it
// - drive mode write ignored while crystal pins assigned and enabled
// - slow crystal boost bit reads as constant one
// - unimplemented bits read as zero
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "clk_mode_consts.svh"
module system_clock_mode_control
(
  // clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // cpu and system inputs
  input wire logic cpu_stop_i,
  input wire logic wake_i,
  input wire logic watchdog_en_i,
  input wire logic fast_xtal_pins_assigned_i,
  // clock tree control
  output logic [2:0] sys_clk_div_sel_o,
  output logic sys_clk_on_o,
  output logic sys_clk_is_slow_o,
  output logic fast_src_sel_o,
  output logic slow_src_sel_o,
  output logic fast_clock_on_o,
  output logic slow_clock_on_o,
  output logic internal_fast_osc_on_o,
  output logic external_fast_xtal_on_o,
  output logic internal_slow_osc_on_o,
  output logic external_slow_xtal_on_o,
  output clk_mode_pkg::rc_freq_e rc_freq_applied_o,
  output logic xtal_fast_drive_sel_o,
  output logic cpu_halted_o,
  output clk_mode_pkg::op_mode_e op_mode_o
);
  import clk_mode_pkg::*;

  // register storage
  logic [7:0] system_clock_select;
  logic [1:0] rc_fast_freq_sel;
  logic rc_fast_enable;
  logic xtal_fast_drive_sel;
  logic xtal_fast_enable;
  logic xtal_slow_enable;
  rc_freq_e rc_freq_applied;
  logic halted;
  logic pend_rc;
  op_mode_e op_mode;

  // bus handshake state
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;

  // rc control reset value, split into its fields on reset
  localparam logic [7:0] rc_ctl_rst = `RC_CTL_RESET;

  // register field names
  wire [2:0] sys_clk_div_sel = system_clock_select[`SCC_DIV_MSB:`SCC_DIV_LSB];
  wire fast_src_sel = system_clock_select[`SCC_FAST_SRC];
  wire slow_src_sel = system_clock_select[`SCC_SLOW_SRC];
  wire fast_keep_alive = system_clock_select[`SCC_FAST_KEEP];
  wire slow_keep_alive = system_clock_select[`SCC_SLOW_KEEP];

  // oscillator settle timers
  osc_settle_if rc_if ();
  osc_settle_if xf_if ();
  osc_settle_if xs_if ();
  logic rc_restart;
  logic xf_restart;
  logic xs_restart;
  wire rc_fast_stable = rc_if.stable;
  wire xtal_fast_stable = xf_if.stable;
  wire xtal_slow_stable = xs_if.stable;

  osc_settle #(.SETTLE_CYC(12'(`RC_SETTLE_CYC))) u_rc_settle
  (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(rc_restart),
    .port(rc_if.osc)
  );
  osc_settle #(.SETTLE_CYC(12'(`XT_FAST_SETTLE_CYC))) u_xf_settle
  (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(xf_restart),
    .port(xf_if.osc)
  );
  osc_settle #(.SETTLE_CYC(12'(`XT_SLOW_SETTLE_CYC))) u_xs_settle
  (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(xs_restart),
    .port(xs_if.osc)
  );

  // write acceptance and decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction
  wire wr_fire = aw_held && w_held && !bvalid;
  wire wr_lane0 = wr_fire && w_strb[0];
  wire wr_scc = wr_lane0 && hit(aw_addr, `ADDR_SYS_CLK_SEL);
  wire wr_rc = wr_lane0 && hit(aw_addr, `ADDR_FAST_RC_CTL);
  wire wr_xf = wr_lane0 && hit(aw_addr, `ADDR_FAST_XT_CTL);
  wire wr_xs = wr_lane0 && hit(aw_addr, `ADDR_SLOW_XT_CTL);
  wire wr_known = hit(aw_addr, `ADDR_SYS_CLK_SEL) || hit(aw_addr, `ADDR_FAST_RC_CTL) ||
    hit(aw_addr, `ADDR_FAST_XT_CTL) || hit(aw_addr, `ADDR_SLOW_XT_CTL);
  wire [7:0] wb = w_data[7:0];
  // drive mode locked while pins belong to the oscillator and it runs
  wire drive_locked = fast_xtal_pins_assigned_i && xtal_fast_enable;

  // restart pulses on enable rising or rc frequency change
  assign rc_restart = wr_rc && ((wb[`OSC_ENABLE_BIT] && !rc_fast_enable) ||
    (wb[`RC_FREQ_MSB:`RC_FREQ_LSB] != rc_fast_freq_sel));
  assign xf_restart = wr_xf && wb[`OSC_ENABLE_BIT] && !xtal_fast_enable;
  assign xs_restart = wr_xs && wb[`OSC_ENABLE_BIT] && !xtal_slow_enable;

  // channel readiness
  assign s_axi_awready_o = !aw_held;
  assign s_axi_wready_o = !w_held;
  assign s_axi_arready_o = !rvalid;

  // write address and data capture
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i || wr_fire)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid_i && !aw_held)
        aw_held <= 1'b1;
      if (s_axi_wvalid_i && !w_held)
        w_held <= 1'b1;
    end
  end
  always_ff @(posedge clock_i)
  begin
    if (s_axi_awvalid_i && !aw_held)
      aw_addr <= s_axi_awaddr_i;
    if (s_axi_wvalid_i && !w_held)
    begin
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end
  end

  // write response
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid <= 1'b1;
      bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready_i)
      bvalid <= 1'b0;
  end

  // register writes
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      system_clock_select <= `SCC_RESET;
      rc_fast_freq_sel <= rc_ctl_rst[`RC_FREQ_MSB:`RC_FREQ_LSB];
      rc_fast_enable <= rc_ctl_rst[`OSC_ENABLE_BIT];
      xtal_fast_drive_sel <= 1'b0;
      xtal_fast_enable <= 1'b0;
      xtal_slow_enable <= 1'b0;
    end
    else
    begin
      if (wr_scc)
        system_clock_select <= {wb[7:5], 1'b0, wb[3:0]};
      if (wr_rc)
      begin
        rc_fast_freq_sel <= wb[`RC_FREQ_MSB:`RC_FREQ_LSB];
        rc_fast_enable <= wb[`OSC_ENABLE_BIT];
      end
      if (wr_xf && !drive_locked)
        xtal_fast_drive_sel <= wb[`OSC_MODE_BIT];
      if (wr_xf)
        xtal_fast_enable <= wb[`OSC_ENABLE_BIT];
      if (wr_xs)
        xtal_slow_enable <= wb[`OSC_ENABLE_BIT];
    end
  end

  // rc frequency takes effect after the stable flag rises
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      pend_rc <= 1'b0;
      rc_freq_applied <= RC_8MHZ;
    end
    else if (rc_restart)
      pend_rc <= 1'b1;
    else if (pend_rc && rc_fast_stable)
    begin
      pend_rc <= 1'b0;
      rc_freq_applied <= rc_freq_e'(rc_fast_freq_sel);
    end
  end

  // read mux
  wire [7:0] rd_scc = system_clock_select;
  wire [7:0] rd_rc = {4'h0, rc_fast_freq_sel, rc_fast_stable, rc_fast_enable};
  wire [7:0] rd_xf = {5'h00, xtal_fast_drive_sel, xtal_fast_stable, xtal_fast_enable};
  wire [7:0] rd_xs = {5'h00, 1'b1, xtal_slow_stable, xtal_slow_enable};
  wire [7:0] rd_byte = hit(s_axi_araddr_i, `ADDR_SYS_CLK_SEL) ? rd_scc :
    hit(s_axi_araddr_i, `ADDR_FAST_RC_CTL) ? rd_rc :
    hit(s_axi_araddr_i, `ADDR_FAST_XT_CTL) ? rd_xf :
    hit(s_axi_araddr_i, `ADDR_SLOW_XT_CTL) ? rd_xs : 8'h00;
  wire rd_known = hit(s_axi_araddr_i, `ADDR_SYS_CLK_SEL) || hit(s_axi_araddr_i, `ADDR_FAST_RC_CTL) ||
    hit(s_axi_araddr_i, `ADDR_FAST_XT_CTL) || hit(s_axi_araddr_i, `ADDR_SLOW_XT_CTL);

  // read response
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid_i && !rvalid)
    begin
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_byte};
      rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready_i)
      rvalid <= 1'b0;
  end

  // halt state: stop enters, wake leaves
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i || wake_i)
      halted <= 1'b0;
    else if (cpu_stop_i)
      halted <= 1'b1;
  end

  // mode decode
  wire slow_sel = (sys_clk_div_sel == `DIV_SEL_SLOW);
  always_comb
  begin
    if (!halted)
      op_mode = slow_sel ? MODE_SLOW : MODE_FAST;
    else
      unique case ({fast_keep_alive, slow_keep_alive})
        2'b00: op_mode = MODE_SLEEP;
        2'b01: op_mode = MODE_STANDBY_SLOW_ONLY;
        2'b11: op_mode = MODE_STANDBY_BOTH_CLOCKS;
        2'b10: op_mode = MODE_STANDBY_FAST_ONLY;
      endcase
  end

  // clock gating by mode
  wire fast_run = (op_mode == MODE_FAST) || (op_mode == MODE_STANDBY_BOTH_CLOCKS) ||
    (op_mode == MODE_STANDBY_FAST_ONLY) ||
    ((op_mode == MODE_SLOW) && (fast_src_sel ? xtal_fast_enable : rc_fast_enable));
  wire slow_run = (op_mode == MODE_FAST) || (op_mode == MODE_SLOW) ||
    (op_mode == MODE_STANDBY_SLOW_ONLY) || (op_mode == MODE_STANDBY_BOTH_CLOCKS);
  wire sys_on = (op_mode == MODE_FAST) || (op_mode == MODE_SLOW) ||
    (op_mode == MODE_STANDBY_BOTH_CLOCKS) ||
    ((op_mode == MODE_STANDBY_SLOW_ONLY) && slow_sel) ||
    ((op_mode == MODE_STANDBY_FAST_ONLY) && !slow_sel);

  // registered clock tree controls
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      fast_clock_on_o <= 1'b1;
      slow_clock_on_o <= 1'b1;
      sys_clk_on_o <= 1'b1;
      internal_fast_osc_on_o <= 1'b1;
      external_fast_xtal_on_o <= 1'b0;
      internal_slow_osc_on_o <= 1'b1;
      external_slow_xtal_on_o <= 1'b0;
      op_mode_o <= MODE_FAST;
    end
    else
    begin
      fast_clock_on_o <= fast_run;
      slow_clock_on_o <= slow_run;
      sys_clk_on_o <= sys_on;
      internal_fast_osc_on_o <= fast_run && !fast_src_sel;
      external_fast_xtal_on_o <= fast_run && fast_src_sel;
      internal_slow_osc_on_o <= (slow_run && !slow_src_sel) || watchdog_en_i;
      external_slow_xtal_on_o <= slow_run && slow_src_sel;
      op_mode_o <= op_mode;
    end
  end

  // plain register-driven outputs
  assign sys_clk_div_sel_o = sys_clk_div_sel;
  assign sys_clk_is_slow_o = slow_sel;
  assign fast_src_sel_o = fast_src_sel;
  assign slow_src_sel_o = slow_src_sel;
  assign rc_freq_applied_o = rc_freq_applied;
  assign xtal_fast_drive_sel_o = xtal_fast_drive_sel;
  assign cpu_halted_o = halted;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;
  assign rc_if.enable = rc_fast_enable;
  assign xf_if.enable = xtal_fast_enable;
  assign xs_if.enable = xtal_slow_enable;

  // sleep stops everything but the watchdog clock
  a_sleep_clocks_off: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (halted && !fast_keep_alive && !slow_keep_alive) |=> !fast_clock_on_o && !slow_clock_on_o && !sys_clk_on_o)
    else $error("sleep left a clock running");
  a_idle_slow_only: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (halted && !fast_keep_alive && slow_keep_alive) |=> slow_clock_on_o && !fast_clock_on_o)
    else $error("slow-only idle clocks wrong");
  a_idle_both_on: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (halted && fast_keep_alive && slow_keep_alive) |=> slow_clock_on_o && fast_clock_on_o && sys_clk_on_o)
    else $error("both-clock idle clocks wrong");
  a_idle_fast_only: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (halted && fast_keep_alive && !slow_keep_alive) |=> fast_clock_on_o && !slow_clock_on_o)
    else $error("fast-only idle clocks wrong");
  a_idle_sys_gate: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (halted && (fast_keep_alive != slow_keep_alive)) |=> sys_clk_on_o == $past(fast_keep_alive != slow_sel))
    else $error("idle system clock gating wrong");
  a_rc_restart_clr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    rc_restart |=> !rc_fast_stable)
    else $error("rc stable not cleared");
  a_xf_restart_clr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    xf_restart |=> !xtal_fast_stable)
    else $error("fast crystal stable not cleared");
  a_xs_restart_clr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    xs_restart |=> !xtal_slow_stable)
    else $error("slow crystal stable not cleared");
  a_drive_lock: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (wr_xf && drive_locked) |=> $stable(xtal_fast_drive_sel))
    else $error("locked drive mode changed");
  a_rc_apply_stable: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $changed(rc_freq_applied) |-> $past(rc_fast_stable))
    else $error("rc frequency applied before stable");
endmodule

/* File: tb/system_clock_mode_control_tb.sv */
`timescale 1ns/10ps
module system_clock_mode_control_tb;
  import clk_mode_pkg::*;
  logic clock_i, sys_rst_i, awvalid, wvalid, bready, arvalid, rready, cpu_stop, wake, wdog, pins;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic awready, wready, bvalid, arready, rvalid, sys_on, is_slow, fsrc, ssrc, fon, son, ifo, efx, iso, esx, drv;
  logic halted;
  logic [1:0] bresp, rresp;
  logic [2:0] div;
  rc_freq_e rcf;
  op_mode_e mode;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  system_clock_mode_control dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .cpu_stop_i(cpu_stop), .wake_i(wake), .watchdog_en_i(wdog), .fast_xtal_pins_assigned_i(pins),
    .sys_clk_div_sel_o(div), .sys_clk_on_o(sys_on), .sys_clk_is_slow_o(is_slow),
    .fast_src_sel_o(fsrc), .slow_src_sel_o(ssrc), .fast_clock_on_o(fon), .slow_clock_on_o(son),
    .internal_fast_osc_on_o(ifo), .external_fast_xtal_on_o(efx), .internal_slow_osc_on_o(iso),
    .external_slow_xtal_on_o(esx), .rc_freq_applied_o(rcf), .xtal_fast_drive_sel_o(drv),
    .cpu_halted_o(halted), .op_mode_o(mode));

  // clock generation
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // hang guard
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // write with both channels offered together, held until taken
  task automatic axi_write(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge clock_i);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge clock_i);
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge clock_i);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_write(a, d, 4'hf, r);
    check("bresp", 32'h0, {30'h0, r});
  endtask

  task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(name, {24'h000000, exp}, d);
    check("rresp", 32'h0, {30'h0, r});
  endtask

  // reset values, constant boost bit, unmapped and masked accesses
  task automatic t_reset_map();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk("sys clk reset", 4'h0, 8'h00);
    rd_chk("fast xtal reset", 4'h8, 8'h00);
    rd_chk("slow xtal reset", 4'hc, 8'h04);
    check("op mode reset", {29'h0, MODE_FAST}, {29'h0, mode});
    check("ext osc reset", 32'h0, {30'h0, efx, esx});
    axi_write(4'h1, 8'hff, 4'hf, r);
    check("unmapped bresp", 32'h2, {30'h0, r});
    axi_read(4'h1, d, r);
    check("unmapped rresp", 32'h2, {30'h0, r});
    check("unmapped rdata", 32'h0, d);
    axi_write(4'h0, 8'hff, 4'he, r);
    rd_chk("masked write", 4'h0, 8'h00);
  endtask

  // clock select fields and unimplemented bit
  task automatic t_select();
    wr(4'h0, 8'hff);
    rd_chk("sys clk bits", 4'h0, 8'hef);
    check("div slow", 32'h7, {29'h0, div});
    check("is slow", 32'h1, {31'h0, is_slow});
    check("src sel", 32'h3, {30'h0, fsrc, ssrc});
    wr(4'h0, 8'he4);
    wr(4'h4, 8'h00);
    tick(2);
    check("fast off in slow", 32'h0, {31'h0, fon});
    wr(4'h4, 8'h01);
    tick(2);
    check("fast on in slow", 32'h1, {31'h0, fon});
    check("fast osc sel", 32'h2, {30'h0, ifo, efx});
    wr(4'h0, 8'h00);
    check("div fast", 32'h0, {30'h0, fsrc, is_slow});
  endtask

  // rc frequency codes applied only after settling
  task automatic t_rc();
    logic [1:0] prev;
    logic [1:0] code;
    tick(170);
    rd_chk("rc settled", 4'h4, 8'h03);
    prev = 2'h0;
    for (int i = 1; i <= 4; i++)
    begin
      code = i[1:0];
      wr(4'h4, {4'h0, code, 2'b01});
      rd_chk("rc unstable", 4'h4, {4'h0, code, 2'b01});
      check("rc freq held", {30'h0, prev}, {30'h0, rcf});
      tick(170);
      rd_chk("rc stable", 4'h4, {4'h0, code, 2'b11});
      check("rc freq applied", {30'h0, code}, {30'h0, rcf});
      prev = code;
    end
    wr(4'h4, 8'h00);
    rd_chk("rc disabled", 4'h4, 8'h00);
    wr(4'h4, 8'h01);
    tick(170);
    rd_chk("rc reenabled", 4'h4, 8'h03);
  endtask

  // crystals: stable flags and drive mode lock
  task automatic t_xtal();
    pins <= 1'b0;
    wr(4'h8, 8'h04);
    wr(4'h8, 8'h05);
    rd_chk("fx unstable", 4'h8, 8'h05);
    tick(1290);
    rd_chk("fx stable", 4'h8, 8'h07);
    pins <= 1'b1;
    wr(4'h8, 8'h01);
    rd_chk("drive locked", 4'h8, 8'h07);
    check("drive out", 32'h1, {31'h0, drv});
    pins <= 1'b0;
    wr(4'h8, 8'h01);
    rd_chk("drive free", 4'h8, 8'h03);
    wr(4'h8, 8'h00);
    wr(4'hc, 8'h01);
    rd_chk("sx unstable", 4'hc, 8'h05);
    tick(4010);
    rd_chk("sx stable", 4'hc, 8'h07);
    wr(4'h0, 8'h04);
    tick(2);
    check("sx on", 32'h1, {31'h0, esx});
  endtask

  // stop instruction in every keep-alive combination
  task automatic t_modes();
    logic fk, sk, sl, exp_sys;
    op_mode_e em;
    for (int i = 0; i < 8; i++)
    begin
      {sl, fk, sk} = i[2:0];
      wdog <= sl;
      wr(4'h0, {sl ? 3'h7 : 3'h0, 3'b000, fk, sk});
      cpu_stop <= 1'b1;
      tick(1);
      cpu_stop <= 1'b0;
      tick(3);
      em = fk ? (sk ? MODE_STANDBY_BOTH_CLOCKS : MODE_STANDBY_FAST_ONLY)
        : (sk ? MODE_STANDBY_SLOW_ONLY : MODE_SLEEP);
      exp_sys = (fk && sk) || (fk && !sl) || (sk && sl);
      check("halted", 32'h1, {31'h0, halted});
      check("stop mode", {29'h0, em}, {29'h0, mode});
      check("clocks on", {30'h0, fk, sk}, {30'h0, fon, son});
      check("sys clk on", {31'h0, exp_sys}, {31'h0, sys_on});
      if (!fk && !sk)
        check("slow rc wdog", {31'h0, sl}, {31'h0, iso});
      wake <= 1'b1;
      tick(1);
      wake <= 1'b0;
      tick(3);
      check("woken", 32'h0, {31'h0, halted});
      check("run mode", {29'h0, sl ? MODE_SLOW : MODE_FAST}, {29'h0, mode});
    end
  endtask

  // main sequence
  initial
  begin
    sys_rst_i = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, cpu_stop, wake, wdog, pins} = '0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wstrb = 4'h0;
    wdata = 32'h0;
    tick(8);
    sys_rst_i <= 1'b0;
    tick(1);
    t_reset_map();
    tick(200);
    t_select();
    t_rc();
    t_xtal();
    t_modes();
    print_verdict();
  end
endmodule
